/* src/ata_cmd_pkg.sv */
// Package: task-file offsets, command codes, status bits and timing for the
// block-count and self-diagnosis command engine.
// Assumes a 10 MHz mclk shared by both ends.
package ata_cmd_pkg;
    // ****************************************
    // Task-file offsets
    // ****************************************
    localparam logic [9:0] OFS_ERROR = 10'h1F1;
    localparam logic [9:0] OFS_SECTOR_COUNT = 10'h1F2;
    localparam logic [9:0] OFS_SECTOR_NUMBER = 10'h1F3;
    localparam logic [9:0] OFS_CYLINDER_LOW = 10'h1F4;
    localparam logic [9:0] OFS_CYLINDER_HIGH = 10'h1F5;
    localparam logic [9:0] OFS_DRIVE_HEAD = 10'h1F6;
    localparam logic [9:0] OFS_COMMAND = 10'h1F7;
    // ****************************************
    // Commands and codes
    // ****************************************
    localparam logic [7:0] CMD_SET_MULTIPLE = 8'hC6;
    localparam logic [7:0] CMD_DIAGNOSE = 8'h90;
    localparam logic [7:0] DIAG_OK = 8'h01;
    localparam logic [7:0] DIAG_BUFFER_ERR = 8'h03;
    localparam logic [7:0] DIAG_ROM_ERR = 8'h05;
    localparam logic [7:0] DIAG_PEER_FAIL = 8'h80;
    localparam logic [7:0] ERR_ABORTED = 8'h04;
    localparam logic [15:0] ID_WORD47 = 16'h0020;
    localparam logic [7:0] ID_WORD59_ON = 8'h01;
    localparam logic [7:0] SECTOR_NUMBER_CHS = 8'h01;
    localparam logic [7:0] SECTOR_NUMBER_LBA = 8'h00;
    localparam logic [7:0] CYLINDER_LOW_DIAG = 8'h02;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_ERROR = 0;
    localparam int DH_DRIVE = 4;
    localparam int DH_LBA = 6;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int PEER_WAIT_S = 5;
    localparam int PEER_WAIT_CYC = PEER_WAIT_S * CLK_HZ;
    localparam int SELF_TEST_CYC = 16;

    function automatic logic block_count_ok(input logic [7:0] v);
        return (v == 8'h02) || (v == 8'h04) || (v == 8'h08) || (v == 8'h10)
            || (v == 8'h20);
    endfunction : block_count_ok
endpackage : ata_cmd_pkg

/* src/ata_link_if.sv */
// Interface: host-to-drive task-file port plus the peer-diagnosis line.
// Assumes the bench resolves the open-drain diagnosis line from its enables.
`timescale 1ns/1ps
interface ata_link_if;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic intrq;
    logic soft_reset;
    logic peer_pass_n;

    modport drive (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata,
        output intrq,
        input soft_reset,
        input peer_pass_n
    );
    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata,
        input intrq,
        output soft_reset
    );
endinterface : ata_link_if

/* src/wait_timer.sv */
// Cycle timer: pulses done after a loaded count or stops on abort.
// Assumes start and abort are one-cycle pulses in the mclk domain.
`timescale 1ns/1ps
module wait_timer #(
    parameter int WIDTH = 26
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [WIDTH-1:0] count,
    input wire logic abort,
    output logic done
);
    logic [WIDTH-1:0] left;
    logic run;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            left <= '0;
            run <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                left <= count;
                run <= 1'b1;
            end else if (abort) begin
                run <= 1'b0;
            end else if (run) begin
                if (left <= WIDTH'(1)) begin
                    run <= 1'b0;
                    done <= 1'b1;
                end else begin
                    left <= left - WIDTH'(1);
                end
            end
        end
    end
endmodule : wait_timer

/* src/ata_drive_end.sv */
// Drive end: task file, block-count command and self-diagnosis engine.
// Assumes host strobes synchronous to mclk; peer line already resolved.
`timescale 1ns/1ps
module ata_drive_end
    import ata_cmd_pkg::*;
#(
    parameter int PEER_WAIT = PEER_WAIT_CYC,
    parameter int SELF_TEST = SELF_TEST_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    ata_link_if.drive link,
    input wire logic is_device1,
    input wire logic peer_present,
    input wire logic [7:0] self_test_code,
    output logic peer_pass_n_out,
    output logic peer_pass_oe,
    output logic multiple_enabled,
    output logic [5:0] sectors_per_request,
    output logic [15:0] id_word47,
    output logic [15:0] id_word59
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_MULT = 4'b0010,
        S_TEST = 4'b0100,
        S_PEER = 4'b1000
    } state_t;

    state_t state;
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    logic [7:0] cylinder_low;
    logic [7:0] cylinder_high;
    logic [7:0] drive_head_select;
    logic [7:0] error_code;
    logic [7:0] status_flags;
    logic [7:0] block_count;
    logic [7:0] own_code;
    logic test_done;
    logic peer_timeout;
    logic selected;
    logic wr_cmd;

    // ****************************************
    // Decode
    // ****************************************
    assign selected = (drive_head_select[DH_DRIVE] == is_device1);
    assign wr_cmd = link.wr && (link.addr == OFS_COMMAND);

    wait_timer #(.WIDTH(26)) test_timer (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(wr_cmd && link.wdata == CMD_DIAGNOSE && state == S_IDLE),
        .count(26'(SELF_TEST)),
        .abort(1'b0),
        .done(test_done)
    );
    wait_timer #(.WIDTH(26)) peer_timer (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(state == S_TEST && test_done && !is_device1 && peer_present),
        .count(26'(PEER_WAIT)),
        .abort(state == S_PEER && !link.peer_pass_n),
        .done(peer_timeout)
    );

    // ****************************************
    // Task file writes
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sector_count <= 8'h00;
            cylinder_low <= 8'h00;
            cylinder_high <= 8'h00;
            drive_head_select <= 8'h00;
        end else if (link.wr && !status_flags[ST_BUSY]) begin
            case (link.addr)
                OFS_SECTOR_COUNT: sector_count <= link.wdata;
                OFS_CYLINDER_LOW: cylinder_low <= link.wdata;
                OFS_CYLINDER_HIGH: cylinder_high <= link.wdata;
                OFS_DRIVE_HEAD: drive_head_select <= link.wdata;
                default: ;
            endcase
        end else if (state == S_TEST && test_done) begin
            cylinder_low <= CYLINDER_LOW_DIAG;
            cylinder_high <= 8'h00;
            sector_count <= 8'h01;
        end
    end

    // ****************************************
    // Command engine
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= S_IDLE;
            status_flags <= 8'h40;
            error_code <= DIAG_OK;
            own_code <= DIAG_OK;
            multiple_enabled <= 1'b0;
            block_count <= 8'h00;
            sector_number <= SECTOR_NUMBER_CHS;
            link.intrq <= 1'b0;
            peer_pass_n_out <= 1'b1;
            peer_pass_oe <= 1'b0;
        end else if (link.soft_reset) begin
            state <= S_IDLE;
            status_flags <= 8'h40;
            link.intrq <= 1'b0;
            peer_pass_oe <= 1'b0;
        end else begin
            if (link.wr && link.addr == OFS_SECTOR_NUMBER && !status_flags[ST_BUSY])
                sector_number <= link.wdata;
            if (link.rd && link.addr == OFS_COMMAND)
                link.intrq <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (wr_cmd && link.wdata == CMD_DIAGNOSE) begin
                        state <= S_TEST;
                        status_flags <= 8'h80;
                        link.intrq <= 1'b0;
                        peer_pass_oe <= 1'b0;
                    end else if (wr_cmd && link.wdata == CMD_SET_MULTIPLE && selected) begin
                        state <= S_MULT;
                        status_flags <= 8'h80;
                        link.intrq <= 1'b0;
                    end
                end
                S_MULT: begin
                    state <= S_IDLE;
                    if (block_count_ok(sector_count)) begin
                        multiple_enabled <= 1'b1;
                        block_count <= sector_count;
                        status_flags <= 8'h40;
                    end else if (sector_count == 8'h00) begin
                        multiple_enabled <= 1'b0;
                        status_flags <= 8'h40;
                    end else begin
                        multiple_enabled <= 1'b0;
                        error_code <= ERR_ABORTED;
                        status_flags <= 8'h41;
                    end
                    link.intrq <= 1'b1;
                end
                S_TEST: begin
                    if (test_done) begin
                        own_code <= self_test_code;
                        error_code <= self_test_code;
                        sector_number <= drive_head_select[DH_LBA] ? SECTOR_NUMBER_LBA
                                                                     : SECTOR_NUMBER_CHS;
                        if (is_device1) begin
                            state <= S_IDLE;
                            status_flags <= 8'h40;
                            peer_pass_n_out <= 1'b0;
                            peer_pass_oe <= (self_test_code == DIAG_OK);
                        end else if (peer_present) begin
                            state <= S_PEER;
                        end else begin
                            state <= S_IDLE;
                            status_flags <= 8'h40;
                            link.intrq <= 1'b1;
                        end
                    end
                end
                S_PEER: begin
                    if (!link.peer_pass_n || peer_timeout) begin
                        state <= S_IDLE;
                        status_flags <= 8'h40;
                        link.intrq <= 1'b1;
                        if (link.peer_pass_n)
                            error_code <= own_code | DIAG_PEER_FAIL;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // Reads and identify words
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            link.rdata <= 8'h00;
            id_word47 <= 16'h0000;
            id_word59 <= 16'h0000;
            sectors_per_request <= 6'h01;
        end else begin
            id_word47 <= ID_WORD47;
            id_word59 <= multiple_enabled ? {ID_WORD59_ON, block_count} : 16'h0000;
            sectors_per_request <= multiple_enabled ? block_count[5:0] : 6'h01;
            case (link.addr)
                OFS_ERROR: link.rdata <= error_code;
                OFS_SECTOR_COUNT: link.rdata <= sector_count;
                OFS_SECTOR_NUMBER: link.rdata <= sector_number;
                OFS_CYLINDER_LOW: link.rdata <= cylinder_low;
                OFS_CYLINDER_HIGH: link.rdata <= cylinder_high;
                OFS_DRIVE_HEAD: link.rdata <= drive_head_select;
                OFS_COMMAND: link.rdata <= status_flags;
                default: link.rdata <= 8'h00;
            endcase
        end
    end
endmodule : ata_drive_end

/* src/ata_host_end.sv */
// Host end: turns user orders into task-file writes and status polls.
// Assumes the drive answers reads one cycle after the strobe.
`timescale 1ns/1ps
module ata_host_end
    import ata_cmd_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    ata_link_if.host link,
    input wire logic go,
    input wire logic diagnose,
    input wire logic [7:0] block_count,
    input wire logic select_device1,
    output logic done,
    output logic [7:0] result_code,
    output logic failed
);
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_SEL = 5'b00010,
        H_CMD = 5'b00100,
        H_WAIT = 5'b01000,
        H_READ = 5'b10000
    } hstate_t;
    hstate_t st;
    logic [1:0] rd_step;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= H_IDLE;
            link.addr <= 10'h000;
            link.wdata <= 8'h00;
            link.wr <= 1'b0;
            link.rd <= 1'b0;
            link.soft_reset <= 1'b0;
            done <= 1'b0;
            result_code <= 8'h00;
            failed <= 1'b0;
            rd_step <= 2'd0;
        end else begin
            link.wr <= 1'b0;
            link.rd <= 1'b0;
            done <= 1'b0;
            case (st)
                H_IDLE: if (go) begin
                    link.wr <= 1'b1;
                    link.addr <= OFS_DRIVE_HEAD;
                    link.wdata <= {3'b000, select_device1, 4'h0};
                    st <= H_SEL;
                end
                H_SEL: begin
                    link.wr <= 1'b1;
                    link.addr <= OFS_SECTOR_COUNT;
                    link.wdata <= block_count;
                    st <= H_CMD;
                end
                H_CMD: begin
                    link.wr <= 1'b1;
                    link.addr <= OFS_COMMAND;
                    link.wdata <= diagnose ? CMD_DIAGNOSE : CMD_SET_MULTIPLE;
                    st <= H_WAIT;
                end
                H_WAIT: if (link.intrq) begin
                    link.rd <= 1'b1;
                    link.addr <= OFS_COMMAND;
                    rd_step <= 2'd0;
                    st <= H_READ;
                end
                H_READ: begin
                    rd_step <= rd_step + 2'd1;
                    if (rd_step == 2'd0) begin
                        link.rd <= 1'b1;
                        link.addr <= OFS_ERROR;
                    end else if (rd_step == 2'd1) begin
                        failed <= link.rdata[ST_ERROR];
                    end else begin
                        result_code <= link.rdata;
                        done <= 1'b1;
                        st <= H_IDLE;
                    end
                end
                default: st <= H_IDLE;
            endcase
        end
    end
endmodule : ata_host_end

/* test/ata_link_properties.sv */
// Checker: timing and codes on the host-to-drive-0 link.
// Assumes host end and drive 0 share this link; inputs are link signals.
`timescale 1ns/1ps
module ata_link_properties
    import ata_cmd_pkg::*;
#(
    parameter int PEER_WAIT = 50,
    parameter int SELF_TEST = 16
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic intrq,
    input wire logic soft_reset,
    input wire logic peer_pass_n
);
    localparam int DIAG_MAX = SELF_TEST + PEER_WAIT + 40;
    logic [7:0] last_cmd;
    logic [7:0] sc_val;
    logic irq_seen;
    wire cmd_wr = wr && addr == OFS_COMMAND;
    wire st_rd = rd && addr == OFS_COMMAND;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Error reads only count once the command has finished
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            last_cmd <= 8'h00;
            irq_seen <= 1'b0;
        end else begin
            if (cmd_wr) begin
                last_cmd <= wdata;
            end
            irq_seen <= cmd_wr ? 1'b0 : (irq_seen | intrq);
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sc_val <= 8'h00;
        end else if (wr && addr == OFS_SECTOR_COUNT) begin
            sc_val <= wdata;
        end
    end
    sequence c6_issue;
        cmd_wr && wdata == CMD_SET_MULTIPLE;
    endsequence
    sequence diag_issue;
        cmd_wr && wdata == CMD_DIAGNOSE;
    endsequence
    c6_irq_a: assert property (c6_issue |-> ##[1:3] intrq)
        else $error("no interrupt after block count command");
    diag_irq_a: assert property (diag_issue |-> ##[1:DIAG_MAX] intrq)
        else $error("no interrupt after diagnosis");
    diag_quiet_a: assert property (diag_issue |-> ##2 !intrq [*8])
        else $error("diagnosis ended too early");
    irq_hold_a: assert property (intrq && !st_rd && !cmd_wr && !soft_reset |=> intrq)
        else $error("interrupt dropped without status read");
    irq_clear_a: assert property (intrq && st_rd |=> !intrq)
        else $error("interrupt kept after status read");
    done_status_a: assert property (intrq && st_rd |=> !rdata[ST_BUSY] && rdata[ST_READY])
        else $error("busy still set at completion");
    diag_code_a: assert property (rd && addr == OFS_ERROR && irq_seen
        && last_cmd == CMD_DIAGNOSE |=> rdata[6:0] inside {7'h01, 7'h03, 7'h05})
        else $error("unknown diagnostic code");
    abort_flag_a: assert property (intrq && st_rd && last_cmd == CMD_SET_MULTIPLE
        && sc_val != 8'h00 |=> rdata[ST_ERROR]
        == !(sc_val inside {8'h02, 8'h04, 8'h08, 8'h10, 8'h20}))
        else $error("error flag wrong for block count");
    pass_line_a: assert property ($fell(peer_pass_n) |-> last_cmd == CMD_DIAGNOSE)
        else $error("pass line asserted outside diagnosis");
endmodule : ata_link_properties

/* test/multiple_mode_and_diagnostic_cmds_test.sv */
// Testbench: host end and drive 0 on one link; drive 1 on a second link
// that mirrors the host or is driven by the bench. Assumes src compiled first.
`timescale 1ns/1ps
module multiple_mode_and_diagnostic_cmds_test;
    import ata_cmd_pkg::*;
    localparam int PW = 50;
    localparam int STC = 16;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic go = 1'b0;
    logic diag = 1'b0;
    logic sel1 = 1'b0;
    logic present = 1'b1;
    logic own = 1'b0;
    logic b_wr = 1'b0;
    logic b_rd = 1'b0;
    logic b_soft = 1'b0;
    logic d1_irq = 1'b0;
    logic [7:0] bcnt = 8'h00;
    logic [7:0] st0 = 8'h01;
    logic [7:0] st1 = 8'h01;
    logic [9:0] b_addr = 10'h000;
    logic [7:0] b_wdata = 8'h00;
    logic done, failed, me0, me1, po0, po1, oe0, oe1;
    logic [7:0] result, v;
    logic [5:0] spr0, spr1;
    logic [15:0] w47_0, w47_1, w59_0, w59_1;
    logic [7:0] good [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
    logic [7:0] nogo [3] = '{8'h03, 8'h40, 8'hFF};
    logic [7:0] dtab [4][2] = '{'{8'h01, 8'h01}, '{8'h05, 8'h03}, '{8'h01, 8'h05},
        '{8'h03, 8'h03}};
    int bad_count = 0;
    int n_tests = 0;
    ata_link_if link0 ();
    ata_link_if link1 ();
    always #50 mclk = ~mclk;
    // Open-drain pass line with pull-up
    assign link0.peer_pass_n = !((oe0 && !po0) || (oe1 && !po1));
    assign link1.peer_pass_n = link0.peer_pass_n;
    assign link1.addr = own ? b_addr : link0.addr;
    assign link1.wdata = own ? b_wdata : link0.wdata;
    assign link1.wr = own ? b_wr : link0.wr;
    assign link1.rd = own ? b_rd : link0.rd;
    assign link1.soft_reset = own ? b_soft : link0.soft_reset;
    ata_host_end u_ata_host_end (.mclk(mclk), .reset_n(reset_n), .link(link0), .go(go),
        .diagnose(diag), .block_count(bcnt), .select_device1(sel1), .done(done),
        .result_code(result), .failed(failed));
    ata_drive_end #(.PEER_WAIT(PW), .SELF_TEST(STC)) u_ata_drive_end (.mclk(mclk),
        .reset_n(reset_n), .link(link0), .is_device1(1'b0), .peer_present(present),
        .self_test_code(st0), .peer_pass_n_out(po0), .peer_pass_oe(oe0),
        .multiple_enabled(me0), .sectors_per_request(spr0), .id_word47(w47_0),
        .id_word59(w59_0));
    ata_drive_end #(.PEER_WAIT(PW), .SELF_TEST(STC)) u_ata_drive_end_peer (.mclk(mclk),
        .reset_n(reset_n), .link(link1), .is_device1(1'b1), .peer_present(1'b1),
        .self_test_code(st1), .peer_pass_n_out(po1), .peer_pass_oe(oe1),
        .multiple_enabled(me1), .sectors_per_request(spr1), .id_word47(w47_1),
        .id_word59(w59_1));
    ata_link_properties #(.PEER_WAIT(PW), .SELF_TEST(STC)) u_ata_link_properties (
        .mclk(mclk), .reset_n(reset_n), .addr(link0.addr), .wdata(link0.wdata),
        .wr(link0.wr), .rd(link0.rd), .rdata(link0.rdata), .intrq(link0.intrq),
        .soft_reset(link0.soft_reset), .peer_pass_n(link0.peer_pass_n));
    // Drive 1 must stay silent while it only follows the host
    always @(posedge mclk) begin
        if (!own && link1.intrq === 1'b1) begin
            d1_irq <= 1'b1;
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("tests %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic hw_reset();
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        // Identify words load on the first edge after release; look one edge later
        repeat (2) @(posedge mclk);
    endtask : hw_reset
    task automatic host_cmd(input logic d, input logic [7:0] c);
        @(posedge mclk);
        go <= 1'b1;
        diag <= d;
        bcnt <= c;
        @(posedge mclk);
        go <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge mclk);
            if (done === 1'b1) begin
                break;
            end
        end
        chk(done, 1'b1);
        repeat (2) @(posedge mclk);
    endtask : host_cmd
    task automatic bwr(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        b_addr <= a;
        b_wdata <= d;
        b_wr <= 1'b1;
        @(posedge mclk);
        b_wr <= 1'b0;
    endtask : bwr
    task automatic brd(input logic [9:0] a);
        @(posedge mclk);
        b_addr <= a;
        b_rd <= 1'b1;
        @(posedge mclk);
        b_rd <= 1'b0;
        @(posedge mclk);
        v = link1.rdata;
    endtask : brd
    task automatic bwait();
        for (int i = 0; i < 100; i++) begin
            brd(OFS_COMMAND);
            if (!v[ST_BUSY]) begin
                break;
            end
        end
        chk(v[ST_BUSY], 1'b0);
    endtask : bwait
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        hw_reset();
        chk(me0, 1'b0);
        chk(w59_0, 16'h0000);
        chk(w47_0, 16'h0020);
        chk(w47_1, 16'h0020);
        foreach (good[i]) begin
            host_cmd(1'b0, good[i]);
            chk(failed, 1'b0);
            chk(me0, 1'b1);
            chk(me1, 1'b0);
            chk(w59_0, {8'h01, good[i]});
            chk(spr0, good[i]);
        end
        foreach (nogo[i]) begin
            host_cmd(1'b0, 8'h10);
            host_cmd(1'b0, nogo[i]);
            chk(failed, 1'b1);
            chk(result, ERR_ABORTED);
            chk(me0, 1'b0);
            chk(w59_0, 16'h0000);
        end
        host_cmd(1'b0, 8'h08);
        host_cmd(1'b0, 8'h00);
        chk(me0, 1'b0);
        chk(spr0, 6'h01);
        host_cmd(1'b0, 8'h20);
        hw_reset();
        chk(me0, 1'b0);
        chk(w59_0, 16'h0000);
        // Last row has no drive 1 as far as drive 0 knows
        for (int i = 0; i < 4; i++) begin
            present <= (i != 3);
            st0 <= dtab[i][0];
            st1 <= dtab[i][1];
            host_cmd(1'b1, 8'h00);
            chk(result, dtab[i][0] | ((i != 3 && dtab[i][1] != 8'h01) ? 8'h80 : 8'h00));
            own <= 1'b1;
            bwr(OFS_DRIVE_HEAD, 8'h10);
            brd(OFS_ERROR);
            chk(v, dtab[i][1]);
            own <= 1'b0;
        end
        chk(d1_irq, 1'b0);
        own <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            bwr(OFS_DRIVE_HEAD, j ? 8'h10 : 8'h50);
            bwr(OFS_COMMAND, CMD_DIAGNOSE);
            bwait();
            brd(OFS_SECTOR_NUMBER);
            chk(v, j ? 8'h01 : 8'h00);
        end
        bwr(OFS_SECTOR_COUNT, 8'h08);
        bwr(OFS_COMMAND, CMD_SET_MULTIPLE);
        bwait();
        b_soft <= 1'b1;
        repeat (2) @(posedge mclk);
        b_soft <= 1'b0;
        @(posedge mclk);
        chk(me1, 1'b1);
        chk(w59_1, 16'h0108);
        brd(OFS_COMMAND);
        chk(v, 8'h40);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        conclude();
    end
endmodule : multiple_mode_and_diagnostic_cmds_test
